// file: logic/ars_pkg.sv
package ars_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int ARS_CLK_HZ = 25_000_000;
  // Restart cushion time is counted in steps of this many milliseconds
  localparam int ARS_CUSH_STEP_MS = 100;
  localparam int ARS_CUSH_STEP_CYC = ARS_CLK_HZ / 1000 * ARS_CUSH_STEP_MS;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam int ARS_AW = 8;
  localparam logic [7:0] ARS_OFS_TUNE = 8'h00;
  localparam logic [7:0] ARS_OFS_MOTOR = 8'h04;
  localparam logic [7:0] ARS_OFS_GAIN = 8'h08;
  localparam logic [7:0] ARS_OFS_THERM = 8'h0C;
  localparam logic [7:0] ARS_OFS_CFG = 8'h10;
  localparam logic [7:0] ARS_OFS_CUSH = 8'h14;
  localparam logic [7:0] ARS_OFS_STAT = 8'h18;
  localparam logic [7:0] ARS_OFS_MCONST = 8'h1C;

  // ****************************************
  // Tuning setting/status codes
  // ****************************************
  localparam logic [7:0] ARS_TS_ARM = 8'h15;
  localparam logic [7:0] ARS_TS_RUN = 8'h16;
  localparam logic [7:0] ARS_TS_DONE = 8'h17;
  localparam logic [7:0] ARS_TS_FORCE = 8'h08;
  localparam logic [7:0] ARS_TS_PROT = 8'h09;
  localparam logic [7:0] ARS_TS_ILIM = 8'h5B;
  localparam logic [7:0] ARS_TS_VBUS = 8'h5C;
  localparam logic [7:0] ARS_TS_CALC = 8'h5D;
  localparam logic [7:0] ARS_TS_RST = 8'h00;

  // ****************************************
  // Motor type codes
  // ****************************************
  localparam logic [7:0] ARS_MOTOR_STD = 8'h03;
  localparam logic [7:0] ARS_MOTOR_CT = 8'h0D;

  // ****************************************
  // Configuration field layout and resets
  // ****************************************
  localparam int ARS_CFG_EXT = 0;
  localparam int ARS_CFG_AUTO = 1;
  localparam int ARS_CFG_MON_LSB = 2;
  localparam logic [1:0] ARS_MON_SPEED = 2'h0;
  localparam logic [1:0] ARS_MON_FREQ = 2'h1;
  localparam logic [3:0] ARS_CFG_RST = 4'h0;
  localparam logic [15:0] ARS_CUSH_RST = 16'h000A;
  localparam logic [15:0] ARS_THERM_RST = 16'h0000;
  localparam logic [15:0] ARS_GAIN_RST = 16'h0000;

  // ****************************************
  // Status word bit positions
  // ****************************************
  localparam int ARS_ST_RUNNING = 0;
  localparam int ARS_ST_TUNING = 1;
  localparam int ARS_ST_ERRLOCK = 2;
  localparam int ARS_ST_CUSHION = 3;
  localparam int ARS_ST_MOTOR_STD = 4;
  localparam int ARS_ST_MOTOR_CT = 5;
  localparam int ARS_ST_SET2_TOG = 6;
  localparam int ARS_ST_STOP_PEND = 7;

  typedef enum logic [1:0] {
    ARS_IDLE,
    ARS_ARMED,
    ARS_TUNE,
    ARS_ENDED
  } ars_tune_state_t;

endpackage

// file: logic/ars_cushion_timer.sv
`timescale 1ns/100ps
module ars_cushion_timer import ars_pkg::*; #(
  parameter int STEP_CYC = ARS_CUSH_STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [15:0] steps,
  // Status
  output logic busy,
  output logic done
);

  logic [31:0] pre_reg;
  logic [15:0] left_reg;

  // ****************************************
  // Step prescaler and step counter
  // ****************************************
  // A zero setting still waits one step so the flags never glitch on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 32'h0;
      left_reg <= 16'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        pre_reg <= 32'h0;
        left_reg <= (steps == 16'h0) ? 16'h1 : steps;
      end else if (busy) begin
        if (pre_reg == 32'(STEP_CYC - 1)) begin
          pre_reg <= 32'h0;
          left_reg <= left_reg - 16'h1;
          if (left_reg == 16'h1) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          pre_reg <= pre_reg + 32'h1;
        end
      end
    end
  end

endmodule

// file: logic/ars_sequencer.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ars_sequencer import ars_pkg::*; #(
  parameter int CUSH_STEP_CYC = ARS_CUSH_STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Start and stop terminals, panel keys
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  input wire logic output_stop_input,
  input wire logic reset_input,
  input wire logic second_set_select,
  input wire logic panel_run_key,
  input wire logic panel_stop_key,
  // Drive conditions
  input wire logic protective_trip,
  input wire logic current_limit_active,
  input wire logic dc_bus_high,
  input wire logic calc_error,
  input wire logic power_loss,
  input wire logic power_restored,
  input wire logic retry_event,
  // Measurement engine
  input wire logic meas_done,
  input wire logic [15:0] meas_gain,
  input wire logic [15:0] meas_const,
  input wire logic [15:0] meas_progress,
  output logic meas_start,
  // Normal operation values
  input wire logic [15:0] set_freq_in,
  input wire logic [15:0] monitor_src,
  input wire logic speed_reached_raw,
  input wire logic freq_detect_raw,
  // Outputs to terminals
  output logic running_output,
  output logic [15:0] analog_monitor_output,
  output logic fault_relay_output,
  output logic speed_reached_flag,
  output logic frequency_detect_flag,
  output logic [15:0] set_freq_monitor,
  output logic retry_suppress,
  output logic restart_active,
  output logic decel_start
);

  ars_tune_state_t state_reg;
  logic [7:0] status_reg;
  logic [7:0] motor_type_select_reg;
  logic [15:0] search_gain_setting_reg;
  logic [15:0] thermal_current_setting_reg;
  logic [3:0] cfg_reg;
  logic [15:0] restart_cushion_time_reg;
  logic [15:0] mconst_reg;
  logic err_lock_reg;
  logic reset_prev_reg;
  logic set2_prev_reg;
  logic set2_tog_reg;
  logic cush_start_reg;
  logic stop_pend_reg;
  logic cush_busy;
  logic cush_done;
  logic start_in;
  logic ext_mode;
  logic start_cond;
  logic force_end;
  logic tuning;
  logic end_evt;
  logic [7:0] end_code;
  logic acc;
  logic wr;
  logic wr_arm;
  logic tune_go;
  logic stop_req;
  logic restart_trig;
  logic mapped;
  logic [31:0] rd_word;

  // ****************************************
  // Decoded conditions
  // ****************************************
  assign start_in = forward_start_input | reverse_start_input;
  assign ext_mode = cfg_reg[ARS_CFG_EXT];
  assign tuning = (state_reg == ARS_TUNE);
  assign start_cond = ext_mode ? start_in : panel_run_key;
  assign tune_go = (state_reg == ARS_ARMED) && start_cond;
  assign force_end = output_stop_input | reset_input | panel_stop_key |
                     (ext_mode & ~start_in);
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  // Re-arming is locked out after an error until a drive reset
  assign wr_arm = wr && (paddr == ARS_OFS_TUNE) &&
                  (pwdata[7:0] == ARS_TS_ARM) && !err_lock_reg &&
                  !tuning;
  assign stop_req = ext_mode ? ~start_in : panel_stop_key;
  assign restart_trig = cfg_reg[ARS_CFG_AUTO] && !tuning &&
                        (power_restored || retry_event ||
                         (reset_prev_reg && !reset_input));

  // ****************************************
  // End cause, most specific first
  // ****************************************
  always_comb begin
    end_evt = 1'b1;
    if (calc_error) begin
      end_code = ARS_TS_CALC;
    end else if (dc_bus_high) begin
      end_code = ARS_TS_VBUS;
    end else if (current_limit_active) begin
      end_code = ARS_TS_ILIM;
    end else if (protective_trip || power_loss) begin
      end_code = ARS_TS_PROT;
    end else if (force_end) begin
      end_code = ARS_TS_FORCE;
    end else if (meas_done) begin
      end_code = ARS_TS_DONE;
    end else begin
      end_code = ARS_TS_RUN;
      end_evt = 1'b0;
    end
  end

  // ****************************************
  // Tuning sequence
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ARS_IDLE;
    end else begin
      unique case (state_reg)
        ARS_IDLE: begin
          if (wr_arm) begin
            state_reg <= ARS_ARMED;
          end
        end
        ARS_ARMED: begin
          if (start_cond) begin
            state_reg <= ARS_TUNE;
          end
        end
        ARS_TUNE: begin
          if (end_evt) begin
            // After a power dip the drive goes straight back to normal
            state_reg <= power_loss ? ARS_IDLE : ARS_ENDED;
          end
        end
        ARS_ENDED: begin
          if (wr_arm) begin
            state_reg <= ARS_ARMED;
          end else if (stop_req) begin
            state_reg <= ARS_IDLE;
          end
        end
      endcase
    end
  end

  // Status code holds its last value until re-armed or reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= ARS_TS_RST;
    end else if (tune_go) begin
      status_reg <= ARS_TS_RUN;
    end else if (wr_arm) begin
      status_reg <= ARS_TS_ARM;
    end else if (tuning && end_evt) begin
      status_reg <= end_code;
    end
  end

  // Error lock: a new error wins over a drive reset in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_lock_reg <= 1'b0;
    end else if (tuning && end_evt && end_code != ARS_TS_DONE) begin
      err_lock_reg <= 1'b1;
    end else if (reset_input) begin
      err_lock_reg <= 1'b0;
    end
  end

  // Gain and motor constant take tuning results only on a clean finish; gain also takes bus writes at any time but the clean-finish cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      search_gain_setting_reg <= ARS_GAIN_RST;
      mconst_reg <= ARS_GAIN_RST;
    end else if (tuning && end_evt && end_code == ARS_TS_DONE) begin
      search_gain_setting_reg <= meas_gain;
      mconst_reg <= meas_const;
    end else if (wr && paddr == ARS_OFS_GAIN) begin
      search_gain_setting_reg <= pwdata[15:0];
    end
  end

  // Second-set select must stay put while tuning runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set2_prev_reg <= 1'b0;
      set2_tog_reg <= 1'b0;
    end else begin
      set2_prev_reg <= second_set_select;
      if (tuning && (second_set_select != set2_prev_reg)) begin
        set2_tog_reg <= 1'b1;
      end else if (wr_arm) begin
        set2_tog_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs during tuning
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running_output <= 1'b0;
      meas_start <= 1'b0;
      retry_suppress <= 1'b0;
      set_freq_monitor <= 16'h0000;
      fault_relay_output <= 1'b0;
    end else begin
      running_output <= tune_go || (tuning && !end_evt);
      meas_start <= tune_go;
      retry_suppress <= tune_go || tuning;
      set_freq_monitor <= (tune_go || tuning) ? 16'h0000 : set_freq_in;
      fault_relay_output <= protective_trip;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_monitor_output <= 16'h0000;
    end else if (tuning) begin
      if (cfg_reg[ARS_CFG_MON_LSB +: 2] == ARS_MON_SPEED ||
          cfg_reg[ARS_CFG_MON_LSB +: 2] == ARS_MON_FREQ) begin
        analog_monitor_output <= meas_progress;
      end else begin
        analog_monitor_output <= 16'h0000;
      end
    end else begin
      analog_monitor_output <= monitor_src;
    end
  end

  // ****************************************
  // Automatic restart cushion
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_prev_reg <= 1'b0;
      cush_start_reg <= 1'b0;
    end else begin
      reset_prev_reg <= reset_input;
      cush_start_reg <= restart_trig && !cush_busy;
    end
  end

  ars_cushion_timer #(
    .STEP_CYC(CUSH_STEP_CYC)
  ) u_cushion (
    .clk(clk),
    .rst(rst),
    .start(cush_start_reg),
    .steps(restart_cushion_time_reg),
    .busy(cush_busy),
    .done(cush_done)
  );

  // Stop asked during the cushion is held until the cushion ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_pend_reg <= 1'b0;
      decel_start <= 1'b0;
    end else begin
      decel_start <= cush_done && (stop_pend_reg || stop_req);
      if (cush_done) begin
        stop_pend_reg <= 1'b0;
      end else if ((cush_busy || cush_start_reg) && stop_req) begin
        stop_pend_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restart_active <= 1'b0;
      speed_reached_flag <= 1'b0;
      frequency_detect_flag <= 1'b0;
    end else begin
      restart_active <= cush_start_reg || (cush_busy && !cush_done);
      speed_reached_flag <= speed_reached_raw && !cush_busy &&
                            !cush_start_reg && !tuning;
      frequency_detect_flag <= freq_detect_raw && !cush_busy &&
                               !cush_start_reg && !tuning;
    end
  end

  // ****************************************
  // APB slave, one wait state per access
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_type_select_reg <= ARS_MOTOR_STD;
      thermal_current_setting_reg <= ARS_THERM_RST;
      cfg_reg <= ARS_CFG_RST;
      restart_cushion_time_reg <= ARS_CUSH_RST;
    end else if (wr && !tuning) begin
      // Motor, thermal, config and cushion settings are frozen while tuning so only the start and stop inputs steer it
      if (paddr == ARS_OFS_MOTOR) begin
        motor_type_select_reg <= pwdata[7:0];
      end
      if (paddr == ARS_OFS_THERM) begin
        thermal_current_setting_reg <= pwdata[15:0];
      end
      if (paddr == ARS_OFS_CFG) begin
        cfg_reg <= pwdata[3:0];
      end
      if (paddr == ARS_OFS_CUSH) begin
        restart_cushion_time_reg <= pwdata[15:0];
      end
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      ARS_OFS_TUNE: rd_word[7:0] = status_reg;
      ARS_OFS_MOTOR: rd_word[7:0] = motor_type_select_reg;
      ARS_OFS_GAIN: rd_word[15:0] = search_gain_setting_reg;
      ARS_OFS_THERM: rd_word[15:0] = thermal_current_setting_reg;
      ARS_OFS_CFG: rd_word[3:0] = cfg_reg;
      ARS_OFS_CUSH: rd_word[15:0] = restart_cushion_time_reg;
      ARS_OFS_STAT: begin
        rd_word[ARS_ST_RUNNING] = running_output;
        rd_word[ARS_ST_TUNING] = tuning;
        rd_word[ARS_ST_ERRLOCK] = err_lock_reg;
        rd_word[ARS_ST_CUSHION] = cush_busy;
        rd_word[ARS_ST_MOTOR_STD] =
          (motor_type_select_reg == ARS_MOTOR_STD);
        rd_word[ARS_ST_MOTOR_CT] =
          (motor_type_select_reg == ARS_MOTOR_CT);
        rd_word[ARS_ST_SET2_TOG] = set2_tog_reg;
        rd_word[ARS_ST_STOP_PEND] = stop_pend_reg;
      end
      ARS_OFS_MCONST: rd_word[15:0] = mconst_reg;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
      end
    end
  end

endmodule

// file: testbench/ars_asserts.sv
`timescale 1ns/100ps
module ars_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Terminals and drive
  input wire logic output_stop_input,
  input wire logic protective_trip,
  input wire logic meas_start,
  input wire logic running_output,
  input wire logic [15:0] set_freq_monitor,
  input wire logic retry_suppress,
  input wire logic fault_relay_output,
  input wire logic speed_reached_flag,
  input wire logic frequency_detect_flag,
  input wire logic restart_active,
  input wire logic decel_start
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // ********
  // Properties
  // ********
  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_start;
    $rose(running_output) |-> meas_start;
  endproperty
  a_start: assert property (p_start) else $error("no start pulse");
  property p_retry;
    running_output |-> retry_suppress;
  endproperty
  a_retry: assert property (p_retry) else $error("retry allowed");
  property p_zero;
    running_output |-> set_freq_monitor == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("set freq not zero");
  property p_stop;
    running_output && output_stop_input |=> !running_output;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_relay;
    protective_trip |=> fault_relay_output;
  endproperty
  a_relay: assert property (p_relay) else $error("relay silent");
  property p_flags;
    restart_active |-> !speed_reached_flag && !frequency_detect_flag;
  endproperty
  a_flags: assert property (p_flags) else $error("flag in restart");
  // Deceleration may only follow the end of the cushion
  property p_hold;
    restart_active |-> !decel_start;
  endproperty
  a_hold: assert property (p_hold) else $error("early decel");
  property p_decel;
    decel_start |-> $past(restart_active) ##1 !decel_start;
  endproperty
  a_decel: assert property (p_decel) else $error("decel misplaced");
  c_tune: cover property ($rose(running_output));
  c_rest: cover property ($fell(restart_active));
  c_decel: cover property (decel_start);
  c_err: cover property (pslverr);
endmodule

bind ars_sequencer ars_asserts chk_u (.clk, .rst, .psel, .penable,
  .pready, .pslverr, .output_stop_input, .protective_trip, .meas_start,
  .running_output, .set_freq_monitor, .retry_suppress,
  .fault_relay_output, .speed_reached_flag, .frequency_detect_flag,
  .restart_active, .decel_start);

// file: testbench/ars_motor_model.sv
`timescale 1ns/100ps
module ars_motor_model #(
  parameter int DLY = 40,
  parameter logic [15:0] GAIN = 16'h2A5C,
  parameter logic [15:0] MCONST = 16'h0C31
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencer side
  input wire logic meas_start,
  input wire logic running_output,
  output logic meas_done,
  output logic [15:0] meas_gain,
  output logic [15:0] meas_const,
  output logic [15:0] meas_progress
);
  int cnt;
  // Motor stands still: measuring just takes time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      meas_done <= 1'h0;
    end else begin
      meas_done <= (cnt == 1) && running_output;
      if (meas_start) cnt <= DLY;
      else if (!running_output) cnt <= 0;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
  // Results are garbage outside the done cycle, so late sampling shows
  assign meas_gain = meas_done ? GAIN : ~GAIN;
  assign meas_const = meas_done ? MCONST : ~MCONST;
  assign meas_progress = 16'(cnt);
endmodule

// file: testbench/tb_autotune_restart_sequencer.sv
`timescale 1ns/100ps
module tb_autotune_restart_sequencer import ars_pkg::*;;
  localparam logic [15:0] MGAIN = 16'h2A5C;
  localparam logic [15:0] MCON = 16'h0C31;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic forward_start_input = 1'h0, reverse_start_input = 1'h0;
  logic reset_input = 1'h0, second_set_select = 1'h0, err;
  logic panel_run_key = 1'h0, power_restored = 1'h0, retry_event = 1'h0;
  logic speed_reached_raw = 1'h1, freq_detect_raw = 1'h1;
  logic [15:0] set_freq_in = 16'h0123, monitor_src = 16'h0456;
  logic [6:0] flt = 7'h00;
  logic panel_stop_key, output_stop_input, power_loss, protective_trip;
  logic current_limit_active, dc_bus_high, calc_error;
  logic meas_done, meas_start, running_output, fault_relay_output;
  logic speed_reached_flag, frequency_detect_flag, retry_suppress;
  logic restart_active, decel_start;
  logic [15:0] meas_gain, meas_const, meas_progress;
  logic [15:0] analog_monitor_output, set_freq_monitor;
  int n_mismatch = 0;
  int samples_checked = 0;
  int sels[11] = '{0, 1, 2, 3, 4, 5, 7, 9, 8, 6, 8};
  logic [7:0] exps[11] = '{ARS_TS_CALC, ARS_TS_VBUS, ARS_TS_ILIM,
    ARS_TS_PROT, ARS_TS_PROT, ARS_TS_FORCE, ARS_TS_FORCE, ARS_TS_FORCE,
    ARS_TS_DONE, ARS_TS_FORCE, ARS_TS_DONE};
  assign {panel_stop_key, output_stop_input, power_loss, protective_trip,
    current_limit_active, dc_bus_high, calc_error} = flt;

  ars_sequencer #(.CUSH_STEP_CYC(4)) dut_u (.*);
  ars_motor_model #(.DLY(40), .GAIN(MGAIN), .MCONST(MCON)) model_u (.clk,
    .rst, .meas_start, .running_output, .meas_done, .meas_gain,
    .meas_const, .meas_progress);

  always #20 clk = ~clk;

  // ********
  // Bus and compare tasks
  // ********
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'h1 && i < 50);
    if (i >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // Polls a status output with a bound so a hang is reported, not hidden
  task wt(input int w, input logic v);
    int i;
    logic s;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      s = (w == 0) ? running_output : restart_active;
      if (s === v) break;
    end
    chk("wait", 32'(s), 32'(v));
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ********
  // One tuning run ended by the chosen cause
  // ********
  task tune(input logic ext, input int sel, input logic [7:0] e);
    logic [15:0] p;
    apb(1'h1, ARS_OFS_CFG, !ext ? 32'h4 : (sel == 5 ? 32'h9 : 32'h1));
    apb(1'h1, ARS_OFS_GAIN, 32'h55);
    apb(1'h1, ARS_OFS_TUNE, 32'(ARS_TS_ARM));
    rchk("arm", ARS_OFS_TUNE, 32'(ARS_TS_ARM));
    @(posedge clk);
    if (!ext) panel_run_key <= 1'h1;
    else if (sel == 2) reverse_start_input <= 1'h1;
    else forward_start_input <= 1'h1;
    wt(0, 1'h1);
    panel_run_key <= 1'h0;
    @(posedge clk);
    p = meas_progress;
    @(posedge clk);
    chk("mon", 32'(analog_monitor_output),
        sel == 5 ? 32'h0 : 32'(p));
    chk("rsup", 32'(retry_suppress), 32'h1);
    chk("sfm", 32'(set_freq_monitor), 32'h0);
    rchk("run", ARS_OFS_TUNE, 32'(ARS_TS_RUN));
    apb(1'h1, ARS_OFS_MOTOR, 32'(ARS_MOTOR_STD));
    @(posedge clk);
    if (sel < 7) flt[sel] <= 1'h1;
    if (sel == 7) forward_start_input <= 1'h0;
    if (sel == 9) reset_input <= 1'h1;
    @(posedge clk);
    reset_input <= 1'h0;
    wt(0, 1'h0);
    chk("relay", 32'(fault_relay_output), 32'(sel == 3));
    flt <= 7'h00;
    forward_start_input <= 1'h0;
    reverse_start_input <= 1'h0;
    rchk("end", ARS_OFS_TUNE, 32'(e));
    rchk("gain", ARS_OFS_GAIN,
         e == ARS_TS_DONE ? 32'(MGAIN) : 32'h55);
    if (e == ARS_TS_DONE) rchk("mcon", ARS_OFS_MCONST, 32'(MCON));
    rchk("motor", ARS_OFS_MOTOR, 32'(ARS_MOTOR_CT));
    if (e != ARS_TS_DONE) begin
      apb(1'h1, ARS_OFS_TUNE, 32'(ARS_TS_ARM));
      rchk("lock", ARS_OFS_TUNE, 32'(e));
    end
    @(posedge clk);
    flt[6] <= 1'h1;
    reset_input <= 1'h1;
    @(posedge clk);
    flt[6] <= 1'h0;
    reset_input <= 1'h0;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    stop_test;
  end

  initial begin
    int i;
    int c;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    rchk("tune0", ARS_OFS_TUNE, 32'h0);
    rchk("motor0", ARS_OFS_MOTOR, 32'(ARS_MOTOR_STD));
    rchk("cush0", ARS_OFS_CUSH, 32'(ARS_CUSH_RST));
    rchk("cfg0", ARS_OFS_CFG, 32'h0);
    rchk("therm0", ARS_OFS_THERM, 32'h0);
    rchk("stat0", ARS_OFS_STAT, 32'h10);
    apb(1'h0, 8'h40, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    chk("slvrd", rd, 32'h0);
    apb(1'h1, ARS_OFS_MOTOR, 32'(ARS_MOTOR_CT));
    rchk("stat", ARS_OFS_STAT, 32'h20);
    chk("sfm0", 32'(set_freq_monitor), 32'(set_freq_in));
    chk("amon0", 32'(analog_monitor_output), 32'(monitor_src));
    $display("reset test done");
    for (i = 0; i < 11; i++) begin
      tune(i < 9, sels[i], exps[i]);
    end
    $display("tuning test done");
    apb(1'h1, ARS_OFS_CFG, 32'h2);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      if (i == 0) power_restored <= 1'h1;
      if (i == 1) retry_event <= 1'h1;
      if (i == 2) reset_input <= 1'h1;
      @(posedge clk);
      power_restored <= 1'h0;
      retry_event <= 1'h0;
      reset_input <= 1'h0;
      wt(1, 1'h1);
      chk("flags", 32'({speed_reached_flag, frequency_detect_flag}),
          32'h0);
      flt[6] <= 1'h1;
      c = 1;
      while (restart_active === 1'h1 && c < 400) begin
        @(posedge clk);
        flt[6] <= 1'h0;
        c++;
      end
      chk("cush", 32'(c >= 39 && c <= 43), 32'h1);
      chk("decel", 32'(decel_start), 32'h1);
      repeat (2) @(posedge clk);
      chk("rel", 32'({speed_reached_flag, frequency_detect_flag}),
          32'h3);
    end
    $display("restart test done");
    stop_test;
  end
endmodule
